/* File: hdl/iuc_host.sv */
// Host controller that programs the core's interrupt logic and drives its NMI pin.
`timescale 1ns/1ps
module iuc_host (
  // Clock and reset.
  input  wire logic                      clk,
  input  wire logic                      nrst,
  // User command port.
  input  wire logic                      cmdValid,
  input  wire logic [1:0]                cmdOp,
  input  wire logic [iuc_pkg::ADDR_W-1:0] cmdData,
  output logic                           cmdReady,
  output logic                           cmdDone,
  output logic                           cmdError,
  // Core instruction trace, same clock.
  input  wire logic                      instrRetire,
  input  wire logic [iuc_pkg::ADDR_W-1:0] instrAddr,
  input  wire logic [2:0]                instrKind,
  input  wire logic                      isrEntry,
  input  wire logic                      isrIsNmi,
  input  wire logic [iuc_pkg::ADDR_W-1:0] isrAddr,
  // Core programming outputs.
  output logic                           spWrite,
  output logic [iuc_pkg::ADDR_W-1:0]     spData,
  output logic                           matchWrite,
  output logic [iuc_pkg::ADDR_W-1:0]     matchAddr,
  output logic                           matchEnable,
  output logic                           restoreValid,
  output logic [2:0]                     restoreStep,
  output logic                           returnStrobe,
  // NMI pin and its port readback.
  output logic                           nmiPin_n,
  input  wire logic                      port8_bit5_input,
  output logic                           nmiSeen
);

  // ==========================================================
  // Pin synchroniser.
  logic [2:0] pinSync;
  logic       pinLevel;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinSync  <= 3'h7;
      pinLevel <= 1'b1;
    end else begin
      pinSync <= {pinSync[1:0], port8_bit5_input};
      if (pinSync[1] == pinSync[2]) begin
        pinLevel <= pinSync[2];
      end
    end
  end

  // ==========================================================
  // Trace bookkeeping.
  logic [iuc_pkg::ADDR_W-1:0] forbid [iuc_pkg::FORBID_DEPTH];
  logic [iuc_pkg::FORBID_DEPTH-1:0] forbidValid;
  logic [2:0]                 forbidPtr;
  logic [iuc_pkg::ADDR_W-1:0] isrStart [iuc_pkg::ISR_DEPTH];
  logic [iuc_pkg::ISR_DEPTH-1:0] isrValid;
  logic [1:0]                 isrPtr;
  logic [3:0]                 gapLeft;
  logic [3:0]                 next_gap;
  logic                       firstDone;

  function automatic logic [3:0] gapFor(input logic [2:0] kind);
    case (kind)
      iuc_pkg::IUC_K_CLR_REQ,
      iuc_pkg::IUC_K_LOWER_ICR: gapFor = iuc_pkg::GAP_CLR_REQ;
      iuc_pkg::IUC_K_SET_I:     gapFor = iuc_pkg::GAP_SET_I;
      iuc_pkg::IUC_K_LOWER_IPL: gapFor = iuc_pkg::GAP_LOWER_IPL;
      default:                  gapFor = 4'h0;
    endcase
  endfunction

  always_comb begin
    next_gap = gapLeft;
    if (instrRetire) begin
      next_gap = (gapLeft != 4'h0) ? gapLeft - 4'h1 : 4'h0;
      if (gapFor(instrKind) > next_gap) begin
        next_gap = gapFor(instrKind);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gapLeft     <= 4'h0;
      forbidPtr   <= 3'h0;
      forbidValid <= '0;
      firstDone   <= 1'b0;
    end else begin
      gapLeft <= next_gap;
      if (instrRetire) begin
        firstDone <= 1'b1;
      end
      if (instrRetire && gapLeft != 4'h0) begin
        forbid[forbidPtr]      <= instrAddr;
        forbidValid[forbidPtr] <= 1'b1;
        forbidPtr              <= forbidPtr + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      isrPtr   <= 2'h0;
      isrValid <= '0;
    end else if (isrEntry) begin
      isrStart[isrPtr] <= isrAddr;
      isrValid[isrPtr] <= 1'b1;
      isrPtr           <= isrPtr + 2'h1;
    end
  end

  function automatic logic isForbidden(input logic [iuc_pkg::ADDR_W-1:0] a);
    isForbidden = 1'b0;
    for (int i = 0; i < iuc_pkg::FORBID_DEPTH; i++) begin
      if (forbidValid[i] && forbid[i] == a) isForbidden = 1'b1;
    end
    for (int i = 0; i < iuc_pkg::ISR_DEPTH; i++) begin
      if (isrValid[i] && isrStart[i] == a) isForbidden = 1'b1;
    end
  endfunction

  // ==========================================================
  // Handler flags for the flag-restore decision.
  logic inNmi;
  logic needRestore;
  logic nmiRewrote;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      inNmi       <= 1'b0;
      needRestore <= 1'b0;
      nmiRewrote  <= 1'b0;
    end else if (isrEntry) begin
      inNmi       <= isrIsNmi;
      needRestore <= 1'b0;
    end else if (instrRetire) begin
      if (instrKind == iuc_pkg::IUC_K_CTRL_WRITE || instrKind == iuc_pkg::IUC_K_CLR_REQ ||
          instrKind == iuc_pkg::IUC_K_LOWER_ICR || instrKind == iuc_pkg::IUC_K_SET_I) begin
        needRestore <= 1'b1;
      end
      if (inNmi && instrKind != iuc_pkg::IUC_K_SET_I && gapFor(instrKind) != 4'h0) begin
        nmiRewrote <= 1'b1;
      end
      if (inNmi && instrKind == iuc_pkg::IUC_K_CTRL_WRITE) begin
        nmiRewrote <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Command sequencer.
  iuc_pkg::iuc_state_t state;
  logic [7:0]          holdCnt;
  logic                spValid;
  logic                take;
  assign take = cmdValid && cmdReady;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state        <= iuc_pkg::IUC_S_IDLE;
      holdCnt      <= 8'h00;
      spValid      <= 1'b0;
      cmdReady     <= 1'b0;
      cmdDone      <= 1'b0;
      cmdError     <= 1'b0;
      spWrite      <= 1'b0;
      spData       <= iuc_pkg::SP_RESET;
      matchWrite   <= 1'b0;
      matchAddr    <= '0;
      matchEnable  <= 1'b0;
      restoreValid <= 1'b0;
      restoreStep  <= 3'h0;
      returnStrobe <= 1'b0;
      nmiPin_n     <= 1'b1;
      nmiSeen      <= 1'b0;
    end else begin
      cmdDone      <= 1'b0;
      cmdError     <= 1'b0;
      spWrite      <= 1'b0;
      matchWrite   <= 1'b0;
      restoreValid <= 1'b0;
      returnStrobe <= 1'b0;
      case (state)
        iuc_pkg::IUC_S_IDLE: begin
          cmdReady <= 1'b1;
          if (take) begin
            case (cmdOp)
              iuc_pkg::IUC_OP_SET_SP: begin
                if (cmdData[0]) begin
                  cmdError <= 1'b1;
                end else begin
                  spWrite <= 1'b1;
                  spData  <= cmdData;
                  spValid <= 1'b1;
                  cmdDone <= 1'b1;
                end
              end
              iuc_pkg::IUC_OP_SET_MATCH: begin
                if (isForbidden(cmdData) || gapLeft != 4'h0) begin
                  cmdError <= 1'b1;
                end else begin
                  matchWrite  <= 1'b1;
                  matchAddr   <= cmdData;
                  matchEnable <= 1'b1;
                  cmdDone     <= 1'b1;
                end
              end
              iuc_pkg::IUC_OP_NMI: begin
                if (!spValid || !firstDone) begin
                  cmdError <= 1'b1;
                end else begin
                  cmdReady <= 1'b0;
                  nmiSeen  <= 1'b0;
                  nmiPin_n <= 1'b0;
                  holdCnt  <= 8'(iuc_pkg::NMI_HOLD_CLKS - 1);
                  state    <= iuc_pkg::IUC_S_NMI_LOW;
                end
              end
              default: begin
                cmdReady    <= 1'b0;
                restoreStep <= 3'h0;
                state <= (needRestore || nmiRewrote) ? iuc_pkg::IUC_S_RESTORE
                                                     : iuc_pkg::IUC_S_RETURN;
              end
            endcase
          end
        end
        iuc_pkg::IUC_S_NMI_LOW: begin
          if (!pinLevel) nmiSeen <= 1'b1;
          if (holdCnt != 8'h00) begin
            holdCnt <= holdCnt - 8'h01;
          end else begin
            nmiPin_n <= 1'b1;
            holdCnt  <= 8'(iuc_pkg::NMI_HOLD_CLKS - 1);
            state    <= iuc_pkg::IUC_S_NMI_HIGH;
          end
        end
        iuc_pkg::IUC_S_NMI_HIGH: begin
          if (holdCnt != 8'h00) begin
            holdCnt <= holdCnt - 8'h01;
          end else begin
            cmdDone  <= 1'b1;
            cmdError <= !nmiSeen;
            cmdReady <= 1'b1;
            state    <= iuc_pkg::IUC_S_IDLE;
          end
        end
        iuc_pkg::IUC_S_RESTORE: begin
          restoreValid <= 1'b1;
          if (restoreValid) restoreStep <= restoreStep + 3'h1;
          if (restoreValid && restoreStep + 3'h1 == iuc_pkg::RESTORE_LAST) begin
            state <= iuc_pkg::IUC_S_RETURN;
          end
        end
        iuc_pkg::IUC_S_RETURN: begin
          returnStrobe <= 1'b1;
          cmdDone      <= 1'b1;
          cmdReady     <= 1'b1;
          state        <= iuc_pkg::IUC_S_IDLE;
        end
        default: state <= iuc_pkg::IUC_S_IDLE;
      endcase
    end
  end

endmodule

/* File: hdl/iuc_pkg.sv */
// Constants and types shared by the interrupt usage host controller.
// Functional notes
// - A valid stack pointer must be written before any interrupt is accepted; the code checks this for NMI only, not for address match.
// - No interrupt, NMI included, during the first instruction after reset; the code holds back NMI only, address match can be enabled at once.
// - The stack pointer should be loaded with an even address.
// - Never program address match with an interrupt routine's first instruction.
// - Never match the 7 addresses after request clear or priority lowering.
// - Never match the 3 addresses after setting the interrupt enable flag.
// - Never match the 3 addresses after lowering the processor priority level.
// - A handler rewriting interrupt control runs flag-restore before returning.
// - A handler enabling nesting also runs flag-restore before returning.
// - If the NMI handler rewrites interrupt control, every handler runs flag-restore.
// - Flag-restore: select ISP, save, read flags, reload flags, restore, dummy nop.
package iuc_pkg;

  localparam int          ADDR_W         = 24;
  localparam logic [23:0] SP_RESET       = 24'h000016;
  localparam int          CLK_PERIOD_NS  = 4;
  localparam int          NMI_EXTRA_NS   = 300;
  localparam int          NMI_BASE_CLKS  = 2;
  localparam int          NMI_HOLD_CLKS  =
      NMI_BASE_CLKS + (NMI_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  GAP_CLR_REQ    = 4'h7;
  localparam logic [3:0]  GAP_SET_I      = 4'h3;
  localparam logic [3:0]  GAP_LOWER_IPL  = 4'h3;
  localparam int          FORBID_DEPTH   = 8;
  localparam int          ISR_DEPTH      = 4;
  localparam logic [2:0]  RESTORE_LAST   = 3'h5;

  typedef enum logic [1:0] {
    IUC_OP_SET_SP    = 2'b00,
    IUC_OP_SET_MATCH = 2'b01,
    IUC_OP_NMI       = 2'b10,
    IUC_OP_RETURN    = 2'b11
  } iuc_op_t;

  typedef enum logic [2:0] {
    IUC_K_NONE       = 3'b000,
    IUC_K_CLR_REQ    = 3'b001,
    IUC_K_LOWER_ICR  = 3'b010,
    IUC_K_SET_I      = 3'b011,
    IUC_K_LOWER_IPL  = 3'b100,
    IUC_K_CTRL_WRITE = 3'b101
  } iuc_kind_t;

  typedef enum logic [2:0] {
    IUC_S_IDLE     = 3'b000,
    IUC_S_NMI_LOW  = 3'b001,
    IUC_S_NMI_HIGH = 3'b010,
    IUC_S_RESTORE  = 3'b011,
    IUC_S_RETURN   = 3'b100
  } iuc_state_t;

endpackage

/* File: tb/iuc_core_model.sv */
// Behavioural core: stack pointer, NMI entry and NMI pin readback.
`timescale 1ns/1ps
module iuc_core_model #(
  parameter logic [23:0] NMI_VEC = 24'h00f000
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        nrst,
  // Host side.
  input  wire logic        spWrite,
  input  wire logic [23:0] spData,
  input  wire logic        nmiPin_n,
  input  wire logic        matchEnable,
  input  wire logic [23:0] matchAddr,
  input  wire logic        instrRetire,
  input  wire logic [23:0] instrAddr,
  // Core side.
  output logic             port8_bit5_input,
  output logic             isrEntry,
  output logic             isrIsNmi,
  output logic [23:0]      isrAddr,
  output logic [23:0]      spValue,
  output logic             matchHit
);
  // ==========
  // Core behaviour.
  logic pinLast;
  assign port8_bit5_input = nmiPin_n;
  assign isrIsNmi = 1'b1;
  assign isrAddr = NMI_VEC;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) spValue <= 24'h000016;
    else if (spWrite) spValue <= spData;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) matchHit <= 1'b0;
    else matchHit <= instrRetire && matchEnable && instrAddr == matchAddr;
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinLast  <= 1'b1;
      isrEntry <= 1'b0;
    end else begin
      pinLast  <= nmiPin_n;
      isrEntry <= pinLast & ~nmiPin_n;
    end
  end
endmodule

/* File: tb/iuc_host_props.sv */
// Concurrent checks on the ports of the interrupt usage host controller.
`timescale 1ns/1ps
module iuc_host_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        nrst,
  // Observed ports.
  input wire logic        cmdReady,
  input wire logic        cmdDone,
  input wire logic        instrRetire,
  input wire logic        spWrite,
  input wire logic [23:0] spData,
  input wire logic        matchWrite,
  input wire logic        matchEnable,
  input wire logic        restoreValid,
  input wire logic [2:0]  restoreStep,
  input wire logic        returnStrobe,
  input wire logic        nmiPin_n,
  input wire logic        nmiSeen
);
  // ==========
  // Helpers and checks.
  logic       retired;
  logic       spSet;
  logic [7:0] lowCnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      retired <= 1'b0;
      spSet   <= 1'b0;
      lowCnt  <= 8'h00;
    end else begin
      retired <= retired | instrRetire;
      spSet   <= spSet | spWrite;
      lowCnt  <= nmiPin_n ? 8'h00 : lowCnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sp_hold_a: assert property ($changed(spData) |-> spWrite) else $error("sp changed");
  sp_even_a: assert property (spWrite |-> !spData[0]) else $error("odd sp");
  nmi_after_sp_a: assert property ($fell(nmiPin_n) |-> spSet) else $error("nmi early");
  nmi_after_run_a: assert property ($fell(nmiPin_n) |-> retired) else $error("nmi");
  nmi_width_a: assert property ($rose(nmiPin_n) |-> lowCnt == iuc_pkg::NMI_HOLD_CLKS)
    else $error("nmi low width");
  nmi_high_a: assert property ($rose(nmiPin_n) |-> !cmdReady [*8]) else $error("ready");
  nmi_seen_a: assert property ($fell(nmiPin_n) |-> ##[2:12] nmiSeen) else $error("seen");
  restore_order_a: assert property ($rose(restoreValid) |-> restoreStep == 3'h0 ##1
    restoreStep == 3'h1 ##1 restoreStep == 3'h2 ##1 restoreStep == 3'h3 ##1
    restoreStep == 3'h4 ##1 restoreStep == 3'h5 ##1 returnStrobe) else $error("restore");
  return_done_a: assert property (returnStrobe |-> cmdDone) else $error("return");
  match_enable_a: assert property (matchWrite |=> matchEnable) else $error("match");
  cover property ($rose(restoreValid));
  cover property ($rose(nmiPin_n));
  cover property (matchWrite);
endmodule

bind iuc_host iuc_host_props i_props (.clk(clk), .nrst(nrst), .cmdReady(cmdReady),
  .cmdDone(cmdDone), .instrRetire(instrRetire), .spWrite(spWrite), .spData(spData),
  .matchWrite(matchWrite), .matchEnable(matchEnable), .restoreValid(restoreValid),
  .restoreStep(restoreStep), .returnStrobe(returnStrobe), .nmiPin_n(nmiPin_n),
  .nmiSeen(nmiSeen));

/* File: tb/tb.sv */
// Self-checking bench for the interrupt usage host controller.
`timescale 1ns/1ps
module tb;
  // ==========
  // Signals.
  logic        clk, nrst, cmdValid, cmdReady, cmdDone, cmdError, instrRetire, gotErr;
  logic        isrEntry, isrIsNmi, spWrite, matchWrite, matchEnable, restoreValid;
  logic        returnStrobe, nmiPin_n, pinIn, nmiSeen, matchHit;
  logic [1:0]  cmdOp;
  logic [2:0]  instrKind, restoreStep;
  logic [23:0] cmdData, instrAddr, isrAddr, spData, matchAddr, spValue, a, b;
  logic [23:0] forbid[$];
  int          failures, n_compared, cyc, seed, lat, gap;
  iuc_host i_dut (.clk(clk), .nrst(nrst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdData(cmdData), .cmdReady(cmdReady), .cmdDone(cmdDone), .cmdError(cmdError),
    .instrRetire(instrRetire), .instrAddr(instrAddr), .instrKind(instrKind),
    .isrEntry(isrEntry), .isrIsNmi(isrIsNmi), .isrAddr(isrAddr), .spWrite(spWrite),
    .spData(spData), .matchWrite(matchWrite), .matchAddr(matchAddr),
    .matchEnable(matchEnable), .restoreValid(restoreValid), .restoreStep(restoreStep),
    .returnStrobe(returnStrobe), .nmiPin_n(nmiPin_n), .port8_bit5_input(pinIn),
    .nmiSeen(nmiSeen));
  iuc_core_model i_core (.clk(clk), .nrst(nrst), .spWrite(spWrite), .spData(spData),
    .nmiPin_n(nmiPin_n), .port8_bit5_input(pinIn), .isrEntry(isrEntry),
    .isrIsNmi(isrIsNmi), .isrAddr(isrAddr), .spValue(spValue), .matchEnable(matchEnable),
    .matchAddr(matchAddr), .instrRetire(instrRetire), .instrAddr(instrAddr),
    .matchHit(matchHit));
  // ==========
  // Tasks.
  task automatic check(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      failures++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  function automatic logic inF(input logic [23:0] x);
    foreach (forbid[i]) if (forbid[i] === x) return 1'b1;
    return 1'b0;
  endfunction
  task automatic cmd(input logic [1:0] op, input logic [23:0] d, input logic e, input int l);
    int n;
    @(posedge clk);
    cmdOp <= op;
    cmdData <= d;
    cmdValid <= 1'b1;
    n = 0;
    do @(negedge clk); while (cmdReady !== 1'b1 && ++n < 400);
    @(posedge clk);
    cmdValid <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (cmdDone !== 1'b1 && cmdError !== 1'b1 && lat < 400);
    gotErr = cmdError;
    check(gotErr === e && lat == l, "command outcome");
  endtask
  task automatic retire(input logic [23:0] ad, input logic [2:0] k, input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clk);
      instrRetire <= 1'b1;
      instrAddr <= ad + 24'(i);
      instrKind <= (i == 0) ? k : 3'h0;
      if (i > 0 && k != 3'h0) forbid.push_back(ad + 24'(i));
    end
    @(posedge clk);
    instrRetire <= 1'b0;
  endtask
  task automatic conclude();
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ==========
  // Clock, timeout and sequence.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      $display("MISMATCH %0t timeout", $time);
      conclude();
    end
  end
  initial begin
    nrst = 1'b0; cmdValid = 1'b0; cmdOp = 2'h0; cmdData = 24'h0; instrRetire = 1'b0;
    instrAddr = 24'h0; instrKind = 3'h0; failures = 0; n_compared = 0; cyc = 0; seed = 91540;
    forbid.push_back(24'h00f000);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    check(spData === 24'h000016 && spValue === 24'h000016, "reset sp");
    cmd(2'h2, 24'h0, 1'b1, 1);
    retire(24'h000100, 3'h0, 0);
    cmd(2'h2, 24'h0, 1'b1, 1);
    cmd(2'h3, 24'h0, 1'b0, 2);
    check(returnStrobe === 1'b1 && restoreStep === 3'h0, "plain return");
    cmd(2'h0, 24'h000401, 1'b1, 1);
    a = 24'($random(seed)) & 24'hfffffe;
    cmd(2'h0, a, 1'b0, 1);
    check(spData === a, "sp write");
    cmd(2'h2, 24'h0, 1'b0, 2 * iuc_pkg::NMI_HOLD_CLKS + 1);
    check(nmiSeen === 1'b1 && spValue === a, "nmi readback");
    retire(24'h000200, 3'h5, 0);
    cmd(2'h3, 24'h0, 1'b0, 8);
    check(returnStrobe === 1'b1, "return strobe");
    cmd(2'h1, 24'h00f000, inF(24'h00f000), 1);
    for (int k = 1; k <= 4; k++) begin
      gap = (k <= 2) ? 7 : 3;
      a = 24'($random(seed)) & 24'h7ffff0;
      retire(a, 3'(k), gap);
      b = a + 24'(1 + ($unsigned($random(seed)) % gap));
      cmd(2'h1, b, inF(b), 1);
      b = 24'($random(seed)) | 24'h800000;
      cmd(2'h1, b, inF(b), 1);
      check(matchAddr === b && matchEnable === 1'b1, "match write");
      retire(b, 3'h0, 0);
      @(negedge clk);
      check(matchHit === 1'b1, "match hit");
    end
    conclude();
  end
endmodule
